// ===== rtl/wdcl_pkg.sv
/*
 * Constants for the watchdog control logic: register offsets, bit positions,
 * reset values and timing counts.
 * Assumes a Wishbone slave with 32-bit data, each register on one aligned word.
 */
package wdcl_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] WDCL_OFS_CTRL   = 4'h0;
  localparam logic [3:0] WDCL_OFS_CAUSE  = 4'h4;
  localparam logic [3:0] WDCL_OFS_ISTAT  = 4'h8;
  localparam logic [3:0] WDCL_OFS_IMASK  = 4'hc;
  localparam logic [3:0] WDCL_OFS_CMD    = 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int WDCL_B_FLAG   = 7;
  localparam int WDCL_B_IE     = 6;
  localparam int WDCL_B_PS3    = 5;
  localparam int WDCL_B_UNLOCK = 4;
  localparam int WDCL_B_RSTEN  = 3;
  localparam int WDCL_B_CAUSE  = 3;
  localparam int WDCL_B_GIE    = 0;
  localparam int WDCL_B_KICK   = 1;
  localparam int WDCL_B_ACK    = 2;

  localparam logic [7:0] WDCL_CTRL_RST  = 8'h00;
  localparam logic [3:0] WDCL_PS_MAX    = 4'h9;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int WDCL_UNLOCK_CYC   = 4;
  localparam int WDCL_BASE_PERIOD  = 2048;
  localparam int WDCL_OSC_KHZ      = 128;
  localparam int WDCL_CNT_W        = 21;

endpackage

// ===== rtl/wdcl_top.sv
/*
 * Watchdog control logic: control register, protected change window, mode
 * decode, time-out counter on the slow oscillator, reset-cause flag.
 * Assumes a classic Wishbone master on clk and a free-running oscillator clock.
 */
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module wdcl_top
  import wdcl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        osc_clk,
  input  wire logic        always_on_fuse,
  input  wire logic        global_irq_enable,
  input  wire logic        vector_taken,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             timeout_irq,
  output logic             sys_reset_req,
  output logic             irq
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic       ack_r;
  logic [7:0] ctrl_r;
  logic       cause_r;
  logic [1:0] istat_r;
  logic [1:0] imask_r;
  logic [2:0] unlock_cnt_r;
  logic       fuse_r1;
  logic       fuse_r2;
  logic       gie_r1;
  logic       gie_r2;
  logic       vec_r1;
  logic       vec_r2;

  // Address compare shared by the write strobes and the restart command.
  function automatic logic at_ofs(input logic [3:0] adr, input logic [3:0] ofs);
    return adr == ofs;
  endfunction

  // A request is answered one cycle after it is seen. Writes land on the
  // edge at which the master samples ack high, so a master that drops its
  // request before the answer leaves every register untouched.
  wire        req    = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        acc    = wb_cyc_i & wb_stb_i & ack_r;
  wire        wr     = acc & wb_we_i & wb_sel_i[0];
  wire        wr_ctl = wr & at_ofs(wb_adr_i, WDCL_OFS_CTRL);
  wire        wr_cse = wr & at_ofs(wb_adr_i, WDCL_OFS_CAUSE);
  wire        wr_ist = wr & at_ofs(wb_adr_i, WDCL_OFS_ISTAT);
  wire        wr_imk = wr & at_ofs(wb_adr_i, WDCL_OFS_IMASK);
  wire [7:0]  wd     = wb_dat_i[7:0];

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire        fuse_on   = ~fuse_r2;
  wire        rsten_eff = ctrl_r[WDCL_B_RSTEN] | cause_r;
  wire        ie_eff    = ctrl_r[WDCL_B_IE] & ~fuse_on;
  wire        run       = fuse_on | rsten_eff | ie_eff;
  wire        unlocked  = ctrl_r[WDCL_B_UNLOCK];
  wire [3:0]  ps_cur    = {ctrl_r[WDCL_B_PS3], ctrl_r[2:0]};
  wire [3:0]  ps_new    = {wd[WDCL_B_PS3], wd[2:0]};
  wire        vec_edge  = vec_r2;

  // ****************************************************************
  // Time-out event returned from the oscillator domain
  // ****************************************************************
  logic       to_tgl_o_r;
  logic [2:0] to_sync_r;
  logic       kick_tgl_r;
  wire        timeout   = to_sync_r[2] ^ to_sync_r[1];

  // Interrupt mode: flag; pure reset mode or unserviced flag: reset.
  wire        to_irq    = timeout & ie_eff;
  wire        to_rst    = timeout & (fuse_on | (rsten_eff &
                          (~ie_eff | ctrl_r[WDCL_B_FLAG])));

  // ****************************************************************
  // Control register next value
  // ****************************************************************
  logic [7:0] ctrl_nxt;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctl) begin
      ctrl_nxt[WDCL_B_IE] = wd[WDCL_B_IE];
      ctrl_nxt[WDCL_B_UNLOCK] = wd[WDCL_B_UNLOCK];
      if (wd[WDCL_B_RSTEN] | (unlocked & ~cause_r))
        ctrl_nxt[WDCL_B_RSTEN] = wd[WDCL_B_RSTEN];
      if (unlocked && ps_new <= WDCL_PS_MAX) begin
        ctrl_nxt[WDCL_B_PS3] = ps_new[3];
        ctrl_nxt[2:0] = ps_new[2:0];
      end
      if (wd[WDCL_B_FLAG])
        ctrl_nxt[WDCL_B_FLAG] = 1'b0;
    end
    if (unlocked && unlock_cnt_r == 3'(WDCL_UNLOCK_CYC - 1))
      ctrl_nxt[WDCL_B_UNLOCK] = 1'b0;
    if (vec_edge && ctrl_r[WDCL_B_FLAG]) begin
      ctrl_nxt[WDCL_B_FLAG] = 1'b0;
      if (rsten_eff)
        ctrl_nxt[WDCL_B_IE] = 1'b0;
    end
    if (to_irq)
      ctrl_nxt[WDCL_B_FLAG] = 1'b1;
    if (fuse_on) begin
      ctrl_nxt[WDCL_B_RSTEN] = 1'b1;
      ctrl_nxt[WDCL_B_IE] = 1'b0;
    end
  end

  // Unlock window counter restarts on each write that sets the bit.
  logic [2:0] unlock_cnt_nxt;
  assign unlock_cnt_nxt = (wr_ctl & wd[WDCL_B_UNLOCK]) ? 3'h0 :
                          unlocked ? unlock_cnt_r + 3'h1 : 3'h0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r       <= WDCL_CTRL_RST;
      unlock_cnt_r <= 3'h0;
    end else begin
      ctrl_r       <= ctrl_nxt;
      unlock_cnt_r <= unlock_cnt_nxt;
    end
  end

  // ****************************************************************
  // Reset-cause flag: set by our own reset request, cleared by writing zero.
  // The flag sits on rst_b, which models power-on; the system reset that
  // this block requests must not reach rst_b or the flag would be lost.
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      cause_r <= 1'b0;
    else if (to_rst)
      cause_r <= 1'b1;
    else if (wr_cse && !wd[WDCL_B_CAUSE])
      cause_r <= 1'b0;
  end

  // ****************************************************************
  // Sticky status and mask; set wins over write-one-to-clear
  // ****************************************************************
  wire [1:0] ev = {to_rst, to_irq};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      istat_r <= 2'h0;
      imask_r <= 2'h0;
    end else begin
      istat_r <= (istat_r & ~(wr_ist ? wd[1:0] : 2'h0)) | ev;
      if (wr_imk)
        imask_r <= wd[1:0];
    end
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fuse_r1 <= 1'b1;
      fuse_r2 <= 1'b1;
      gie_r1  <= 1'b0;
      gie_r2  <= 1'b0;
      vec_r1  <= 1'b0;
      vec_r2  <= 1'b0;
    end else begin
      fuse_r1 <= always_on_fuse;
      fuse_r2 <= fuse_r1;
      gie_r1  <= global_irq_enable;
      gie_r2  <= gie_r1;
      vec_r1  <= vector_taken;
      vec_r2  <= vec_r1;
    end
  end

  // ****************************************************************
  // Bus answer: one wait state, ack for one cycle
  // ****************************************************************
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0;
    case (wb_adr_i)
      WDCL_OFS_CTRL:  rd_nxt[7:0] = {ctrl_r[7:4], rsten_eff, ctrl_r[2:0]};
      WDCL_OFS_CAUSE: rd_nxt[WDCL_B_CAUSE] = cause_r;
      WDCL_OFS_ISTAT: rd_nxt[1:0] = istat_r;
      WDCL_OFS_IMASK: rd_nxt[1:0] = imask_r;
      default:        rd_nxt = 32'h0;
    endcase
  end

  // The restart command shares the control offset but travels in byte lane 1,
  // so software can restart the counter without touching the control byte.
  wire kick_cmd = acc & wb_we_i & wb_sel_i[1] & at_ofs(wb_adr_i, WDCL_OFS_CTRL) &
                  wb_dat_i[8];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r         <= 1'b0;
      wb_dat_o      <= 32'h0;
      timeout_irq   <= 1'b0;
      sys_reset_req <= 1'b0;
      irq           <= 1'b0;
      kick_tgl_r    <= 1'b0;
    end else begin
      ack_r         <= req;
      wb_dat_o      <= req ? rd_nxt : 32'h0;
      timeout_irq   <= ctrl_nxt[WDCL_B_FLAG] & ctrl_nxt[WDCL_B_IE] & gie_r2;
      sys_reset_req <= to_rst;
      irq           <= |((istat_r | ev) & imask_r);
      kick_tgl_r    <= kick_tgl_r ^ kick_cmd;
    end
  end
  assign wb_ack_o = ack_r;

  // ****************************************************************
  // Oscillator domain counter
  // ****************************************************************
  logic [2:0]            kick_sync_r;
  logic [1:0]            run_sync_r;
  logic [3:0]            ps_s1_r;
  logic [3:0]            ps_s2_r;
  logic [WDCL_CNT_W-1:0] cnt_r;

  // Period select changes rarely and the counter tolerates a stale sample,
  // so a plain two-stage bus sync is enough here.
  wire                  kick_o = kick_sync_r[2] ^ kick_sync_r[1];
  wire [WDCL_CNT_W-1:0] limit  = WDCL_CNT_W'(WDCL_BASE_PERIOD) << ps_s2_r;

  always_ff @(posedge osc_clk or negedge rst_b) begin
    if (!rst_b) begin
      kick_sync_r <= 3'h0;
      run_sync_r  <= 2'h0;
      ps_s1_r     <= 4'h0;
      ps_s2_r     <= 4'h0;
      cnt_r       <= '0;
      to_tgl_o_r  <= 1'b0;
    end else begin
      kick_sync_r <= {kick_sync_r[1:0], kick_tgl_r};
      run_sync_r  <= {run_sync_r[0], run};
      ps_s1_r     <= ps_cur;
      ps_s2_r     <= ps_s1_r;
      if (kick_o || !run_sync_r[1])
        cnt_r <= '0;
      else if (cnt_r >= limit - WDCL_CNT_W'(1)) begin
        cnt_r      <= '0;
        to_tgl_o_r <= ~to_tgl_o_r;
      end else
        cnt_r <= cnt_r + WDCL_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      to_sync_r <= 3'h0;
    else
      to_sync_r <= {to_sync_r[1:0], to_tgl_o_r};
  end

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The counter must hold the longest period, the base period shifted by
  // the largest legal select code, and the unlock counter must reach the
  // end of the change window.
  if (WDCL_CNT_W < 21) begin : g_cnt_too_narrow
    $error("time-out counter too narrow for the longest period");
  end
  if (WDCL_UNLOCK_CYC < 1 || WDCL_UNLOCK_CYC > 8) begin : g_unlock_range
    $error("change window length not served by the unlock counter");
  end
  if (WDCL_PS_MAX > 4'h9) begin : g_ps_range
    $error("period select limit beyond the supported codes");
  end

  // ****************************************************************
  // Limitations
  // ****************************************************************
  // The period select crosses into the oscillator domain as a plain
  // two-stage bus. A change that lands on an oscillator edge may be seen
  // as a mix of old and new codes for one cycle; software restarts the
  // counter after each change, which hides the mixed sample.
  // The time-out travels back as a toggle, so one event can never be
  // counted twice, but two time-outs between the same two clk edges would
  // cancel. The oscillator is far slower than clk, so this cannot happen.
  // The restart command also travels as a toggle. Two restarts between the
  // same two oscillator edges cancel, so the counter is not restarted;
  // restarts an oscillator cycle or more apart each return it to zero.
  // The reset-cause flag lives on rst_b. The system reset request must be
  // routed to the rest of the device, not back onto rst_b, or the flag
  // would be lost together with the reset it reports.
  // Reserved period codes are refused as a whole: the write keeps the old
  // select, so a stray write can never stretch the period beyond the
  // longest legal code.

endmodule

// ===== verif/wdcl_properties.sv
/* Concurrent checks on the ports of the watchdog control logic.
   Assumes it is bound to wdcl_top and that every check runs on clk. */
`timescale 1ns/1ps
module wdcl_properties (
  input logic        clk,
  input logic        rst_b,
  input logic        global_irq_enable,
  input logic        vector_taken,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  input logic        timeout_irq,
  input logic        sys_reset_req,
  input logic        irq
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  ack_one_cycle_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_after_req_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  read_upper_zero_a:
    assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data above byte not zero");
  reset_pulse_a:
    assert property (sys_reset_req |=> !sys_reset_req) else $error("reset request not a pulse");
  flag_sticky_a:
    assert property ((global_irq_enable && !vector_taken && !wb_cyc_i)[*4] ##0 timeout_irq
      |=> timeout_irq) else $error("time-out request dropped by itself");
  vector_clear_a:
    assert property (vector_taken[*8] |-> !timeout_irq) else $error("vector did not clear flag");
  gie_gate_a:
    assert property (!global_irq_enable[*6] |-> !timeout_irq)
    else $error("time-out request without global enable");
  first_timeout_a:
    assert property ($rose(timeout_irq) |-> !sys_reset_req[*4])
    else $error("reset on first time-out");

  cover property ($rose(timeout_irq));
  cover property (sys_reset_req);
  cover property ($rose(irq));
endmodule

// ===== verif/wdcl_top_tb.sv
/* Self-checking testbench for the watchdog control logic.
   Assumes a fast stand-in oscillator so that time-outs fit in a short run. */
`timescale 1ns/1ps
module wdcl_top_tb;
  // ****************************************************************
  // Stimulus, bus tasks and scenarios
  // ****************************************************************
  // The oscillator is sped up and kept out of phase with clk; windows use its period.
  localparam real OSC_NS = 19.4;
  logic        clk, rst_b, osc_clk, always_on_fuse, global_irq_enable, vector_taken;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, timeout_irq, sys_reset_req, irq;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  int          n_errors, checks, n;

  wdcl_top wdcl_top_i (.clk, .rst_b, .osc_clk, .always_on_fuse, .global_irq_enable,
    .vector_taken, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .timeout_irq, .sys_reset_req, .irq);

  always #4 clk = ~clk;
  always #(OSC_NS / 2.0) osc_clk = ~osc_clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic we, input logic [3:0] a, s, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, 4'h1, d);
  endtask

  task automatic rc(input logic [3:0] a, input string nm, input logic [31:0] exp);
    bus(1'b0, a, 4'hf, 32'h0);
    chk(nm, q, exp);
  endtask

  // Restart travels in byte lane 1 only, so the control byte is left alone.
  task automatic kick();
    bus(1'b1, 4'h0, 4'h2, 32'h100);
  endtask

  task automatic wt(input bit rs, input int lim);
    n = 0;
    while ((rs ? sys_reset_req : timeout_irq) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  function automatic logic [31:0] win(input int osc);
    int c;
    c = int'(osc * OSC_NS / 8.0);
    return 32'(n >= c - 30 && n <= c + 60);
  endfunction

  task automatic stop_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #(90000 * 8);
    n_errors++;
    stop_test();
  end

  initial begin
    {clk, rst_b, osc_clk, vector_taken, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    {always_on_fuse, global_irq_enable} = 2'b11;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rc(4'h0, "ctrl_rst", 32'h0);
    rc(4'h4, "cause_rst", 32'h0);
    rc(4'h2, "unmapped", 32'h0);
    wr(4'hc, 32'h1);
    wr(4'h0, 32'h40);
    kick();
    wt(0, 6000);
    chk("t_code0", win(2048), 32'h1);
    rc(4'h0, "flag_set", 32'hc0);
    chk("irq_on", irq, 1'b1);
    wr(4'hc, 32'h0);
    rc(4'h8, "status", 32'h1);
    chk("irq_masked", irq, 1'b0);
    wr(4'h8, 32'h1);
    rc(4'h8, "status_clr", 32'h0);
    wr(4'hc, 32'h1);
    wr(4'h0, 32'hc0);
    rc(4'h0, "flag_w1c", 32'h40);
    global_irq_enable <= 1'b0;
    kick();
    repeat (5100) @(posedge clk);
    rc(4'h0, "flag_no_gie", 32'hc0);
    chk("irq_no_gie", timeout_irq, 1'b0);
    global_irq_enable <= 1'b1;
    repeat (6) @(posedge clk);
    chk("irq_gie", timeout_irq, 1'b1);
    wr(4'h0, 32'hc0);
    repeat (3) begin
      kick();
      repeat (3000) @(posedge clk);
    end
    rc(4'h0, "kicked", 32'h40);
    kick();
    wr(4'h0, 32'h41);
    rc(4'h0, "ps_locked", 32'h40);
    wr(4'h0, 32'h48);
    wr(4'h0, 32'h40);
    rc(4'h0, "rsten_locked", 32'h48);
    wr(4'h0, 32'h58);
    repeat (8) @(posedge clk);
    rc(4'h0, "unlock_gone", 32'h48);
    wr(4'h0, 32'h40);
    rc(4'h0, "late_write", 32'h48);
    wr(4'h0, 32'h58);
    wr(4'h0, 32'h61);
    rc(4'h0, "code9", 32'h61);
    wr(4'h0, 32'h58);
    wr(4'h0, 32'h67);
    rc(4'h0, "code_rsvd", 32'h61);
    wr(4'h0, 32'h58);
    wr(4'h0, 32'h41);
    kick();
    wt(0, 11000);
    chk("t_code1", win(4096), 32'h1);
    wr(4'h0, 32'h58);
    wr(4'h0, 32'hc8);
    kick();
    wt(0, 6000);
    rc(4'h0, "comb_flag", 32'hc8);
    vector_taken <= 1'b1;
    repeat (10) @(posedge clk);
    vector_taken <= 1'b0;
    rc(4'h0, "vector_clr", 32'h08);
    wr(4'h0, 32'h48);
    kick();
    wt(0, 6000);
    wt(1, 6000);
    chk("second_to", win(2048), 32'h1);
    rc(4'h4, "cause_set", 32'h08);
    wr(4'h0, 32'h58);
    wr(4'h0, 32'h00);
    rc(4'h0, "rsten_forced", 32'h88);
    wr(4'h4, 32'h0);
    rc(4'h4, "cause_clr", 32'h0);
    wr(4'h0, 32'h58);
    wr(4'h0, 32'h80);
    rc(4'h0, "stopped", 32'h0);
    kick();
    repeat (5500) @(posedge clk);
    rc(4'h0, "stop_ctrl", 32'h0);
    rc(4'h4, "stop_cause", 32'h0);
    always_on_fuse <= 1'b0;
    kick();
    wt(1, 6000);
    chk("fuse_reset", win(2048), 32'h1);
    always_on_fuse <= 1'b1;
    stop_test();
  end
endmodule

bind wdcl_top wdcl_properties wdcl_properties_i (.clk, .rst_b, .global_irq_enable,
  .vector_taken, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .timeout_irq,
  .sys_reset_req, .irq);
